// file: command_engine.sv
module command_engine (
  input  wire logic       mclk,
  input  wire logic       reset,
  mailbox_if.engine       bus,
  output logic            exec_valid,
  output logic [7:0]      exec_code,
  output logic [7:0]      exec_param,
  input  wire logic       exec_done,
  input  wire logic       exec_invalid,
  input  wire logic       overflow_valid,
  input  wire logic [2:0] overflow_channel
);

  mailbox_pkg::engine_state_t state;
  logic [7:0]                 response;
  logic                       executed;
  logic                       error_held;
  logic                       clear_cmd;

  function automatic logic [7:0] overflow_code(input logic [2:0] channel);
    if (channel < mailbox_pkg::first_light_channel) begin
      overflow_code = mailbox_pkg::proximity_overflow_base + {5'h00, channel};
    end else begin
      overflow_code = mailbox_pkg::light_overflow_base
                      + {5'h00, channel - mailbox_pkg::first_light_channel};
    end
  endfunction : overflow_code

  assign error_held   = response[mailbox_pkg::error_flag_bit];
  assign clear_cmd    = (bus.cmd_byte == mailbox_pkg::no_operation_command)
                     || (bus.cmd_byte == mailbox_pkg::reset_command);
  assign bus.response = response;
  assign bus.executed = executed;

  always_ff @(posedge mclk) begin
    if (reset) begin
      state      <= mailbox_pkg::engine_idle;
      exec_valid <= 1'b0;
      exec_code  <= 8'h00;
      exec_param <= 8'h00;
    end else begin
      case (state)
        mailbox_pkg::engine_idle: begin
          if (bus.cmd_write && !clear_cmd && !error_held) begin
            exec_valid <= 1'b1;
            exec_code  <= bus.cmd_byte;
            exec_param <= bus.param_byte;
            state      <= mailbox_pkg::engine_busy;
          end
        end
        mailbox_pkg::engine_busy: begin
          // a write while busy is dropped; host watches the counter
          if (exec_done) begin
            exec_valid <= 1'b0;
            state      <= mailbox_pkg::engine_idle;
          end
        end
        default: begin
          state <= mailbox_pkg::engine_idle;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      response <= mailbox_pkg::command_response_reset;
      executed <= 1'b0;
    end else begin
      executed <= 1'b0;
      if (bus.resp_write) begin
        response <= bus.resp_data;
      end
      if (bus.cmd_write && clear_cmd) begin
        response <= mailbox_pkg::command_response_reset;
      end
      if (state == mailbox_pkg::engine_busy && exec_done) begin
        if (exec_invalid && !error_held) begin
          response <= mailbox_pkg::invalid_command_error;
        end else if (!error_held) begin
          response <= {4'h0, response[3:0] + mailbox_pkg::counter_step};
          executed <= 1'b1;
        end
      end
      if (overflow_valid && !error_held) begin
        response <= overflow_code(overflow_channel);
      end
    end
  end

endmodule : command_engine

// file: i2c_host_model.sv
module i2c_host_model (
  output logic     scl,
  output logic     pull_low,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ns;
  // quarter of the 320 ns serial period
  localparam int q = 80;
  initial begin
    scl = 1;
    pull_low = 0;
  end
  // link pins move by non-blocking assignment so the sync flops never race
  task automatic put(input logic b);
    pull_low <= ~b;
    #q scl <= 1;
    #(2 * q) scl <= 0;
    #q;
  endtask : put
  // released line floats to the pull-up, never the last value
  task automatic get(output logic b);
    pull_low <= 0;
    #q scl <= 1;
    #q b = sda;
    #q scl <= 0;
    #q;
  endtask : get
  task automatic start;
    pull_low <= 0;
    #q scl <= 1;
    #q pull_low <= 1;
    #q scl <= 0;
    #q;
  endtask : start
  task automatic stop;
    pull_low <= 1;
    #q scl <= 1;
    #q pull_low <= 0;
    #(2 * q);
  endtask : stop
  task automatic send(input logic [7:0] v, inout logic ok);
    logic a;
    for (int i = 7; i >= 0; i--) put(v[i]);
    get(a);
    ok = ok & ~a;
  endtask : send
  task automatic wr(input logic [7:0] a, input logic [7:0] v,
                    output logic ok);
    ok = 1;
    start;
    send({mailbox_pkg::device_address, 1'b0}, ok);
    send(a, ok);
    send(v, ok);
    stop;
  endtask : wr
  task automatic rd(input logic [7:0] a, input int n,
                    output logic [23:0] d, output logic ok);
    logic b;
    ok = 1;
    d = 24'h000000;
    start;
    send({mailbox_pkg::device_address, 1'b0}, ok);
    send(a, ok);
    start;
    send({mailbox_pkg::device_address, 1'b1}, ok);
    for (int k = 0; k < n; k++) begin
      for (int i = 7; i >= 0; i--) begin
        get(b);
        d[8 * k + i] = b;
      end
      put(k == n - 1);
    end
    stop;
  endtask : rd
endmodule : i2c_host_model

// file: mailbox_if.sv
interface mailbox_if;
  logic       cmd_write;
  logic [7:0] cmd_byte;
  logic [7:0] param_byte;
  logic       resp_write;
  logic [7:0] resp_data;
  logic [7:0] response;
  logic       executed;

  modport host_side (
    output cmd_write,
    output cmd_byte,
    output param_byte,
    output resp_write,
    output resp_data,
    input  response,
    input  executed
  );

  modport engine (
    input  cmd_write,
    input  cmd_byte,
    input  param_byte,
    input  resp_write,
    input  resp_data,
    output response,
    output executed
  );
endinterface : mailbox_if

// file: mailbox_pkg.sv
package mailbox_pkg;

  // register byte addresses
  localparam logic [7:0] parameter_mailbox_addr         = 8'h17;
  localparam logic [7:0] command_mailbox_addr           = 8'h18;
  localparam logic [7:0] command_response_addr          = 8'h20;
  localparam logic [7:0] event_flags_addr               = 8'h21;
  localparam logic [7:0] visible_light_result_low_addr  = 8'h22;
  localparam logic [7:0] visible_light_result_high_addr = 8'h23;
  localparam logic [7:0] infrared_light_result_low_addr = 8'h24;

  // reset values
  localparam logic [7:0] parameter_mailbox_reset         = 8'h00;
  localparam logic [7:0] command_mailbox_reset           = 8'h00;
  localparam logic [7:0] command_response_reset          = 8'h00;
  localparam logic [5:0] event_flags_reset               = 6'h00;
  localparam logic [7:0] visible_light_result_low_reset  = 8'h00;
  localparam logic [7:0] visible_light_result_high_reset = 8'h00;
  localparam logic [7:0] infrared_light_result_low_reset = 8'h00;

  // event flag field positions
  localparam int command_flag_bit          = 5;
  localparam int proximity_three_flag_bit  = 4;
  localparam int proximity_two_flag_bit    = 3;
  localparam int proximity_one_flag_bit    = 2;
  localparam int ambient_light_field_lsb   = 0;
  localparam int event_flag_count          = 6;

  // response codes
  localparam int                error_flag_bit        = 7;
  localparam logic [7:0] invalid_command_error = 8'h80;
  localparam logic [7:0] proximity_overflow_base = 8'h88;
  localparam logic [7:0] light_overflow_base     = 8'h8C;
  localparam logic [2:0] first_light_channel     = 3'h3;
  localparam logic [3:0] counter_step            = 4'h1;

  // proximity alert mode that survives auto clear
  localparam logic [1:0] alert_mode_keep = 2'h3;

  // command codes handled in the mailbox itself
  localparam logic [7:0] no_operation_command = 8'h00;
  localparam logic [7:0] reset_command        = 8'h01;

  // serial slave address, value arbitrary
  localparam logic [6:0] device_address = 7'h3C;

  typedef enum logic [6:0] {
    link_idle    = 7'b0000001,
    link_address = 7'b0000010,
    link_ack_out = 7'b0000100,
    link_write   = 7'b0001000,
    link_read    = 7'b0010000,
    link_ack_in  = 7'b0100000,
    link_ignore  = 7'b1000000
  } link_state_t;

  typedef enum logic [1:0] {
    engine_idle = 2'b01,
    engine_busy = 2'b10
  } engine_state_t;

endpackage : mailbox_pkg

// file: mailbox_props.sv
module mailbox_props (
  input wire logic       mclk,
  input wire logic       reset,
  input wire logic       standby,
  input wire logic       int_out_n,
  input wire logic [5:0] irq_enable,
  input wire logic       int_mode,
  input wire logic [5:0] proximity_alert_mode,
  input wire logic       meas_start,
  input wire logic [2:0] prox_event,
  input wire logic [1:0] ambient_event,
  input wire logic       exec_valid,
  input wire logic [7:0] exec_code,
  input wire logic [7:0] exec_param,
  input wire logic       exec_done
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (reset);
  a_exec_hold: assert property (
    exec_valid && !exec_done |=> exec_valid && $stable(exec_code)
      && $stable(exec_param)) else $error("pending command moved");
  a_exec_drop: assert property (
    exec_valid && exec_done |=> !exec_valid) else $error("no release");
  a_wake_first: assert property (
    $rose(exec_valid) |-> !standby) else $error("still asleep");
  a_no_local: assert property (
    $rose(exec_valid) |-> exec_code != 8'h00 && exec_code != 8'h01)
    else $error("local command forwarded");
  // meas_start alone in auto mode must leave the pin idle
  a_auto_clear: assert property (
    int_mode && meas_start && proximity_alert_mode == 6'h00
      && prox_event == 3'h0 && ambient_event == 2'h0 && !exec_done
      && !$past(exec_done)
      |=> int_out_n) else $error("auto clear missed");
  a_prox_irq: assert property (
    prox_event[0] && irq_enable[2] |=> !int_out_n)
    else $error("proximity irq missed");
  a_amb_irq: assert property (
    ambient_event[1] && irq_enable[1] |=> !int_out_n)
    else $error("ambient irq missed");
  a_irq_masked: assert property (
    irq_enable == 6'h00 |=> int_out_n) else $error("masked irq seen");
endmodule : mailbox_props

bind sensor_command_mailbox_irq mailbox_props chk (
  .mclk(mclk), .reset(reset), .standby(standby), .int_out_n(int_out_n),
  .irq_enable(irq_enable), .int_mode(int_mode),
  .proximity_alert_mode(proximity_alert_mode), .meas_start(meas_start),
  .prox_event(prox_event), .ambient_event(ambient_event),
  .exec_valid(exec_valid), .exec_code(exec_code),
  .exec_param(exec_param), .exec_done(exec_done)
);

// file: sensor_command_mailbox_irq.sv
module sensor_command_mailbox_irq (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_n,
  output logic             int_out_n,
  output logic             standby,
  input  wire logic [5:0]  irq_enable,
  input  wire logic        int_mode,
  input  wire logic [5:0]  proximity_alert_mode,
  input  wire logic        sleep_request,
  input  wire logic        meas_start,
  input  wire logic        meas_done,
  input  wire logic [15:0] vis_result,
  input  wire logic [15:0] ir_result,
  input  wire logic [2:0]  prox_event,
  input  wire logic [1:0]  ambient_event,
  output logic             exec_valid,
  output logic [7:0]       exec_code,
  output logic [7:0]       exec_param,
  input  wire logic        exec_done,
  input  wire logic        exec_invalid,
  input  wire logic        overflow_valid,
  input  wire logic [2:0]  overflow_channel
);

  mailbox_if bus ();

  logic [1:0]                scl_sync;
  logic [1:0]                sda_sync;
  logic                      scl_prev;
  logic                      sda_prev;
  logic                      scl_s;
  logic                      sda_s;
  logic                      scl_rise;
  logic                      scl_fall;
  logic                      start_cond;
  logic                      stop_cond;

  mailbox_pkg::link_state_t  state;
  logic [2:0]                bit_count;
  logic [7:0]                shifter;
  logic                      byte_got;
  logic                      drive_low;
  logic                      is_read;
  logic                      first_byte;
  logic [7:0]                pointer;
  logic                      we;
  logic [7:0]                wr_addr;
  logic [7:0]                wr_data;
  logic [7:0]                read_byte;

  logic [7:0]                parameter_mailbox;
  logic [7:0]                command_mailbox;
  logic [5:0]                event_flags;
  logic [7:0]                visible_light_result_low;
  logic [7:0]                visible_light_result_high;
  logic [7:0]                infrared_light_result_low;
  logic [5:0]                flag_set;
  logic [5:0]                flag_w1c;
  logic [5:0]                flag_auto;
  logic [5:0]                next_event_flags;

  // pins cross into mclk through two flops
  always_ff @(posedge mclk) begin
    if (reset) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], scl_in};
      sda_sync <= {sda_sync[0], sda_in};
      scl_prev <= scl_sync[1];
      sda_prev <= sda_sync[1];
    end
  end

  assign scl_s      = scl_sync[1];
  assign sda_s      = sda_sync[1];
  assign scl_rise   = scl_s && !scl_prev;
  assign scl_fall   = !scl_s && scl_prev;
  assign start_cond = scl_s && scl_prev && sda_prev && !sda_s;
  assign stop_cond  = scl_s && scl_prev && !sda_prev && sda_s;

  // open drain: only ever pulls low
  assign sda_out  = 1'b0;
  assign sda_oe_n = !drive_low;

  always_ff @(posedge mclk) begin
    if (reset) begin
      state      <= mailbox_pkg::link_idle;
      bit_count  <= 3'h0;
      shifter    <= 8'h00;
      byte_got   <= 1'b0;
      drive_low  <= 1'b0;
      is_read    <= 1'b0;
      first_byte <= 1'b0;
      pointer    <= 8'h00;
      we         <= 1'b0;
      wr_addr    <= 8'h00;
      wr_data    <= 8'h00;
    end else begin
      we <= 1'b0;
      if (start_cond) begin
        state      <= mailbox_pkg::link_address;
        bit_count  <= 3'h0;
        byte_got   <= 1'b0;
        drive_low  <= 1'b0;
        first_byte <= 1'b1;
      end else if (stop_cond) begin
        state     <= mailbox_pkg::link_idle;
        drive_low <= 1'b0;
      end else begin
        case (state)
          mailbox_pkg::link_address,
          mailbox_pkg::link_write: begin
            if (scl_rise) begin
              shifter   <= {shifter[6:0], sda_s};
              bit_count <= bit_count + 3'h1;
              if (bit_count == 3'h7) begin
                byte_got <= 1'b1;
              end
            end else if (scl_fall && byte_got) begin
              byte_got <= 1'b0;
              if (state == mailbox_pkg::link_address) begin
                if (shifter[7:1] == mailbox_pkg::device_address) begin
                  is_read   <= shifter[0];
                  drive_low <= 1'b1;
                  state     <= mailbox_pkg::link_ack_out;
                end else begin
                  state <= mailbox_pkg::link_ignore;
                end
              end else begin
                drive_low <= 1'b1;
                state     <= mailbox_pkg::link_ack_out;
                if (first_byte) begin
                  pointer    <= shifter;
                  first_byte <= 1'b0;
                end else begin
                  we      <= 1'b1;
                  wr_addr <= pointer;
                  wr_data <= shifter;
                  pointer <= pointer + 8'h01;
                end
              end
            end
          end
          mailbox_pkg::link_ack_out: begin
            if (scl_fall) begin
              bit_count <= 3'h0;
              if (is_read) begin
                shifter   <= read_byte;
                drive_low <= !read_byte[7];
                pointer   <= pointer + 8'h01;
                state     <= mailbox_pkg::link_read;
              end else begin
                drive_low <= 1'b0;
                state     <= mailbox_pkg::link_write;
              end
            end
          end
          mailbox_pkg::link_read: begin
            if (scl_rise) begin
              bit_count <= bit_count + 3'h1;
              if (bit_count == 3'h7) begin
                byte_got <= 1'b1;
              end
            end else if (scl_fall) begin
              if (byte_got) begin
                byte_got  <= 1'b0;
                drive_low <= 1'b0;
                state     <= mailbox_pkg::link_ack_in;
              end else begin
                shifter   <= {shifter[6:0], 1'b0};
                drive_low <= !shifter[6];
              end
            end
          end
          mailbox_pkg::link_ack_in: begin
            if (scl_rise) begin
              if (sda_s) begin
                state <= mailbox_pkg::link_ignore;
              end else begin
                byte_got <= 1'b1;
              end
            end else if (scl_fall && byte_got) begin
              byte_got  <= 1'b0;
              bit_count <= 3'h0;
              shifter   <= read_byte;
              drive_low <= !read_byte[7];
              pointer   <= pointer + 8'h01;
              state     <= mailbox_pkg::link_read;
            end
          end
          mailbox_pkg::link_ignore: begin
            drive_low <= 1'b0;
          end
          default: begin
            state <= mailbox_pkg::link_idle;
          end
        endcase
      end
    end
  end

  // read decode; reserved flag bits read zero
  always_comb begin
    if (pointer == mailbox_pkg::parameter_mailbox_addr) begin
      read_byte = parameter_mailbox;
    end else if (pointer == mailbox_pkg::command_mailbox_addr) begin
      read_byte = command_mailbox;
    end else if (pointer == mailbox_pkg::command_response_addr) begin
      read_byte = bus.response;
    end else if (pointer == mailbox_pkg::event_flags_addr) begin
      read_byte = {2'h0, event_flags};
    end else if (pointer == mailbox_pkg::visible_light_result_low_addr) begin
      read_byte = visible_light_result_low;
    end else if (pointer == mailbox_pkg::visible_light_result_high_addr) begin
      read_byte = visible_light_result_high;
    end else if (pointer == mailbox_pkg::infrared_light_result_low_addr) begin
      read_byte = infrared_light_result_low;
    end else begin
      read_byte = 8'h00;
    end
  end

  assign bus.cmd_write  = we && (wr_addr == mailbox_pkg::command_mailbox_addr);
  assign bus.cmd_byte   = wr_data;
  assign bus.param_byte = parameter_mailbox;
  assign bus.resp_write = we && (wr_addr == mailbox_pkg::command_response_addr);
  assign bus.resp_data  = wr_data;

  always_ff @(posedge mclk) begin
    if (reset) begin
      parameter_mailbox <= mailbox_pkg::parameter_mailbox_reset;
      command_mailbox   <= mailbox_pkg::command_mailbox_reset;
    end else if (we) begin
      if (wr_addr == mailbox_pkg::parameter_mailbox_addr) begin
        parameter_mailbox <= wr_data;
      end else if (wr_addr == mailbox_pkg::command_mailbox_addr) begin
        command_mailbox <= wr_data;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      standby <= 1'b1;
    end else if (bus.cmd_write) begin
      standby <= 1'b0;
    end else if (sleep_request) begin
      standby <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      visible_light_result_low  <= mailbox_pkg::visible_light_result_low_reset;
      visible_light_result_high <= mailbox_pkg::visible_light_result_high_reset;
      infrared_light_result_low <= mailbox_pkg::infrared_light_result_low_reset;
    end else if (meas_done) begin
      visible_light_result_low  <= vis_result[7:0];
      visible_light_result_high <= vis_result[15:8];
      infrared_light_result_low <= ir_result[7:0];
    end else if (we) begin
      if (wr_addr == mailbox_pkg::visible_light_result_low_addr) begin
        visible_light_result_low <= wr_data;
      end else if (wr_addr == mailbox_pkg::visible_light_result_high_addr) begin
        visible_light_result_high <= wr_data;
      end else if (wr_addr == mailbox_pkg::infrared_light_result_low_addr) begin
        infrared_light_result_low <= wr_data;
      end
    end
  end

  always_comb begin
    flag_set = 6'h00;
    flag_set[mailbox_pkg::command_flag_bit]         = bus.executed;
    flag_set[mailbox_pkg::proximity_three_flag_bit] = prox_event[2];
    flag_set[mailbox_pkg::proximity_two_flag_bit]   = prox_event[1];
    flag_set[mailbox_pkg::proximity_one_flag_bit]   = prox_event[0];
    flag_set[mailbox_pkg::ambient_light_field_lsb +: 2] = ambient_event;
  end

  assign flag_w1c = (we && wr_addr == mailbox_pkg::event_flags_addr)
                  ? wr_data[5:0] : 6'h00;

  always_comb begin
    flag_auto = 6'h00;
    if (int_mode && meas_start) begin
      flag_auto = 6'h3F;
      if (proximity_alert_mode[5:4] == mailbox_pkg::alert_mode_keep) begin
        flag_auto[mailbox_pkg::proximity_three_flag_bit] = 1'b0;
      end
      if (proximity_alert_mode[3:2] == mailbox_pkg::alert_mode_keep) begin
        flag_auto[mailbox_pkg::proximity_two_flag_bit] = 1'b0;
      end
      if (proximity_alert_mode[1:0] == mailbox_pkg::alert_mode_keep) begin
        flag_auto[mailbox_pkg::proximity_one_flag_bit] = 1'b0;
      end
    end
  end

  // a set arriving with its clear wins
  assign next_event_flags = (event_flags & ~(flag_w1c | flag_auto)) | flag_set;

  always_ff @(posedge mclk) begin
    if (reset) begin
      event_flags <= mailbox_pkg::event_flags_reset;
    end else begin
      event_flags <= next_event_flags;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      int_out_n <= 1'b1;
    end else begin
      int_out_n <= !(|(next_event_flags & irq_enable));
    end
  end

  command_engine engine_inst (
    .mclk             (mclk),
    .reset            (reset),
    .bus              (bus.engine),
    .exec_valid       (exec_valid),
    .exec_code        (exec_code),
    .exec_param       (exec_param),
    .exec_done        (exec_done),
    .exec_invalid     (exec_invalid),
    .overflow_valid   (overflow_valid),
    .overflow_channel (overflow_channel)
  );

endmodule : sensor_command_mailbox_irq

// file: sensor_command_mailbox_irq_test.sv
module sensor_command_mailbox_irq_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk = 0;
  logic        reset = 1;
  logic [5:0]  irq_enable = 6'h00;
  logic        int_mode = 0;
  logic [5:0]  alert = 6'h00;
  logic [8:0]  pl = 9'h000;
  logic [15:0] vis = 16'h0000;
  logic [15:0] ir = 16'h0000;
  logic        done = 0;
  logic        invalid = 0;
  logic [2:0]  ch = 3'h0;
  logic [7:0]  seen_param, exec_code, exec_param;
  logic        scl, pull_low, sda_out, sda_oe_n, int_out_n, standby;
  logic        exec_valid, ack;
  logic [23:0] d;
  logic [7:0]  codes [6] = '{8'h88, 8'h89, 8'h8A, 8'h8C, 8'h8D, 8'h8E};
  int          bad_count = 0;
  int          tests_run = 0;
  // pull-up: low only while the host or the enabled device drives low
  wire         sda = ~pull_low & (sda_oe_n | sda_out);
  initial forever #20 mclk = ~mclk;
  sensor_command_mailbox_irq uut (
    .mclk(mclk), .reset(reset), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .int_out_n(int_out_n),
    .standby(standby), .irq_enable(irq_enable), .int_mode(int_mode),
    .proximity_alert_mode(alert), .sleep_request(pl[8]),
    .meas_start(pl[0]), .meas_done(pl[1]), .vis_result(vis),
    .ir_result(ir), .prox_event(pl[4:2]), .ambient_event(pl[6:5]),
    .exec_valid(exec_valid), .exec_code(exec_code),
    .exec_param(exec_param), .exec_done(done), .exec_invalid(invalid),
    .overflow_valid(pl[7]), .overflow_channel(ch));
  i2c_host_model host (.scl(scl), .pull_low(pull_low), .sda(sda));
  // sequencer stand-in: code 0x7F is the one it does not know
  always @(posedge mclk) begin
    done <= exec_valid & ~done;
    invalid <= exec_code == 8'h7F;
    if (exec_valid) seen_param <= exec_param;
  end
  task automatic chk_byte(input string n, input logic [7:0] e,
                          input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk_byte
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    host.wr(a, v, ack);
    chk_byte("write_ack", 8'h01, {7'h00, ack});
  endtask : wr
  task automatic rd(input logic [7:0] a, input int n);
    host.rd(a, n, d, ack);
    chk_byte("read_ack", 8'h01, {7'h00, ack});
  endtask : rd
  task automatic pulse(input logic [8:0] v);
    @(posedge mclk) pl <= v;
    @(posedge mclk) pl <= 9'h000;
  endtask : pulse
  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : test_done
  initial begin
    #3_000_000;
    bad_count++;
    test_done;
  end
  initial begin
    repeat (12) @(posedge mclk);
    reset <= 0;
    repeat (4) @(posedge mclk);
    rd(8'h20, 2);
    chk_byte("reset_response", 8'h00, d[7:0]);
    chk_byte("reset_flags", 8'h00, d[15:8]);
    wr(8'h17, 8'h5A);
    rd(8'h30, 1);
    chk_byte("unmapped", 8'h00, d[7:0]);
    chk_byte("still_asleep", 8'h01, {7'h00, standby});
    @(posedge mclk) irq_enable <= 6'h3F;
    wr(8'h18, 8'h10);
    chk_byte("awake", 8'h00, {7'h00, standby});
    chk_byte("param", 8'h5A, seen_param);
    rd(8'h20, 2);
    chk_byte("count_one", 8'h01, d[7:0]);
    chk_byte("cmd_flag", 8'h20, d[15:8]);
    chk_byte("int_on", 8'h00, {7'h00, int_out_n});
    wr(8'h21, 8'h20);
    chk_byte("int_off", 8'h01, {7'h00, int_out_n});
    for (int i = 2; i <= 17; i++) begin
      wr(8'h18, 8'h10);
      rd(8'h20, 1);
      chk_byte("counter", 8'(i % 16), d[7:0]);
    end
    wr(8'h18, 8'h7F);
    wr(8'h18, 8'h10);
    @(posedge mclk) vis <= 16'hA55A;
    @(posedge mclk) ir <= 16'h1234;
    pulse(9'h002);
    rd(8'h20, 1);
    chk_byte("error_held", 8'h80, d[7:0]);
    rd(8'h22, 3);
    chk_byte("vis_low", 8'h5A, d[7:0]);
    chk_byte("vis_high", 8'hA5, d[15:8]);
    chk_byte("ir_low", 8'h34, d[23:16]);
    wr(8'h18, 8'h00);
    rd(8'h20, 1);
    chk_byte("error_gone", 8'h00, d[7:0]);
    for (int i = 0; i < 6; i++) begin
      @(posedge mclk) ch <= 3'(i);
      pulse(9'h080);
      rd(8'h20, 1);
      chk_byte("overflow", codes[i], d[7:0]);
      wr(8'h18, 8'h01);
    end
    @(posedge mclk) int_mode <= 1;
    @(posedge mclk) alert <= 6'h30;
    pulse(9'h07C);
    rd(8'h21, 1);
    chk_byte("flags_all", 8'h3F, d[7:0]);
    pulse(9'h001);
    rd(8'h21, 1);
    chk_byte("flags_kept", 8'h10, d[7:0]);
    @(posedge mclk) alert <= 6'h00;
    pulse(9'h001);
    rd(8'h21, 1);
    chk_byte("flags_auto", 8'h00, d[7:0]);
    chk_byte("int_auto", 8'h01, {7'h00, int_out_n});
    pulse(9'h100);
    // standby updates at the edge the pulse task returns on
    @(negedge mclk);
    chk_byte("asleep", 8'h01, {7'h00, standby});
    test_done;
  end
endmodule : sensor_command_mailbox_irq_test
